/* File: core/adccr_pkg.sv */
package adccr_pkg;
   localparam int unsigned ADDR_W = 13;
   localparam int unsigned INSTR_BITS = 16;
   localparam int unsigned BYTE_BITS = 8;
   localparam int unsigned SYNC_STAGES = 2;

   // register offsets
   localparam logic [12:0] OFS_TEMP_CTRL = 13'h004d;
   localparam logic [12:0] OFS_DIFF_SKEW = 13'h0070;
   localparam logic [12:0] OFS_EDGE_SLIP = 13'h0071;
   localparam logic [12:0] OFS_CLK_DIV = 13'h0072;
   localparam logic [12:0] OFS_OUT_DRV_FMT = 13'h0073;
   localparam logic [12:0] OFS_OUT_TIMING = 13'h0074;

   // values after reset
   localparam logic [7:0] RST_TEMP_CTRL = 8'h00;
   localparam logic [7:0] RST_DIFF_SKEW = 8'h80;
   localparam logic [7:0] RST_EDGE_SLIP = 8'h00;
   localparam logic [7:0] RST_CLK_DIV = 8'h00;
   localparam logic [7:0] RST_OUT_DRV_FMT = 8'h00;
   localparam logic [7:0] RST_OUT_TIMING = 8'h00;

   // field positions
   localparam int unsigned TC_ENABLE_BIT = 7;
   localparam int unsigned TC_PD_BIT = 6;
   localparam int unsigned TC_RESET_BIT = 5;
   localparam int unsigned TC_DIV_LSB = 1;
   localparam int unsigned TC_SELECT_BIT = 0;
   localparam int unsigned SLIP_BIT = 0;
   localparam int unsigned DIV_LSB = 0;
   localparam int unsigned MODE_LSB = 5;
   localparam int unsigned FMT_LSB = 0;
   localparam int unsigned DLL_BIT = 6;
   localparam int unsigned DDR_BIT = 4;
   localparam int unsigned RW_BIT = 15;

   // field codes
   localparam logic [2:0] DIV_PIN = 3'h0;
   localparam logic [2:0] DIV_BY1 = 3'h1;
   localparam logic [2:0] DIV_BY2 = 3'h2;
   localparam logic [2:0] DIV_BY4 = 3'h4;
   localparam logic [2:0] MODE_DIFF_3MA = 3'h0;
   localparam logic [2:0] MODE_DIFF_2MA = 3'h1;
   localparam logic [2:0] MODE_CMOS = 3'h4;
   localparam logic [2:0] FMT_TWOS = 3'h0;
   localparam logic [2:0] FMT_GRAY = 3'h2;
   localparam logic [2:0] FMT_OFFSET = 3'h4;

   // decoded divider ratio on ratio output
   localparam logic [1:0] RATIO_1 = 2'h0;
   localparam logic [1:0] RATIO_2 = 2'h1;
   localparam logic [1:0] RATIO_4 = 2'h2;

   typedef enum logic [0:0] {ST_INSTR, ST_DATA} adccr_state_e;
endpackage : adccr_pkg

/* File: core/adccr_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module adccr_sync #(
   parameter int unsigned WIDTH = 1
) (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_r;

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         meta_r <= '0;
         sync_o <= '0;
      end else begin
         meta_r <= async_i;
         sync_o <= meta_r;
      end
   end
endmodule : adccr_sync
`default_nettype wire

/* File: core/adccr_regs.sv */
// Notes on behaviour
// - divide code: 000 pin, 001 /1, 010 /2, 100 /4
// - mode bits 7:5: 3mA, 2mA, CMOS
// - format bits 2:0: two's, Gray, offset binary
// - DLL range bit: 0 fast, 1 slow, reset 0
// - divide and mode bytes survive soft reset
`timescale 1ns/100ps
`default_nettype none
module adccr_regs (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic soft_reset_i,
   input wire logic spi_sclk_i,
   input wire logic spi_csb_n_i,
   input wire logic spi_sdio_i,
   output logic spi_sdio_o,
   output logic spi_sdio_oe_o,
   output logic [7:0] temp_ctrl_o,
   output logic temp_enable_o,
   output logic counter_power_down_o,
   output logic temp_reset_o,
   output logic [2:0] temp_divider_o,
   output logic temp_select_o,
   output logic [7:0] diff_skew_o,
   output logic edge_slip_o,
   output logic div_pin_ctrl_o,
   output logic [1:0] div_ratio_o,
   output logic div_reserved_o,
   output logic drive_3ma_o,
   output logic drive_2ma_o,
   output logic drive_cmos_o,
   output logic mode_reserved_o,
   output logic fmt_twos_o,
   output logic fmt_gray_o,
   output logic fmt_offset_o,
   output logic fmt_reserved_o,
   output logic dll_slow_o,
   output logic ddr_enable_o
);
   import adccr_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [2:0] pins_s;
   logic sclk_s;
   logic csb_n_s;
   logic sdio_s;
   logic sclk_d_r;

   adccr_sync #(.WIDTH(3)) u_sync (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .async_i({spi_sclk_i, spi_csb_n_i, spi_sdio_i}),
      .sync_o(pins_s)
   );

   assign sclk_s = pins_s[2];
   assign csb_n_s = pins_s[1];
   assign sdio_s = pins_s[0];

   // csb idles high so the sampled low after reset cannot open a false frame
   logic csb_seen_r;
   wire frame_on = ~csb_n_s & csb_seen_r;
   wire sclk_rise = frame_on & sclk_s & ~sclk_d_r;
   wire sclk_fall = frame_on & ~sclk_s & sclk_d_r;

   ////////////////////////////////////////////////////////////////////////////
   // serial engine
   adccr_state_e state_r, state_nxt;
   logic [4:0] bit_cnt_r;
   logic [15:0] in_shift_r;
   logic [7:0] out_shift_r;
   logic [12:0] addr_r;
   logic read_r;

   wire [15:0] in_next = {in_shift_r[14:0], sdio_s};
   wire instr_done = (state_r == ST_INSTR) & sclk_rise & (bit_cnt_r == 5'(INSTR_BITS - 1));
   wire byte_done = (state_r == ST_DATA) & sclk_rise & (bit_cnt_r == 5'(BYTE_BITS - 1));
   wire [12:0] instr_addr = in_next[ADDR_W-1:0];
   wire instr_read = in_next[RW_BIT];
   wire wr_stb = byte_done & ~read_r;
   wire [7:0] wr_data = in_next[7:0];
   wire [12:0] next_addr = addr_r + 13'h0001;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_INSTR: if (instr_done) state_nxt = ST_DATA;
         ST_DATA: state_nxt = ST_DATA;
         default: state_nxt = ST_INSTR;
      endcase
      if (!frame_on) state_nxt = ST_INSTR;
   end

   ////////////////////////////////////////////////////////////////////////////
   // register storage
   logic [7:0] temp_ctrl_r, diff_skew_r, edge_slip_r;
   logic [7:0] clk_div_r, out_drv_fmt_r, out_timing_r;

   function automatic logic [7:0] read_mux(input logic [12:0] a);
      case (a)
         OFS_TEMP_CTRL: read_mux = temp_ctrl_r;
         OFS_DIFF_SKEW: read_mux = diff_skew_r;
         OFS_EDGE_SLIP: read_mux = edge_slip_r;
         OFS_CLK_DIV: read_mux = clk_div_r;
         OFS_OUT_DRV_FMT: read_mux = out_drv_fmt_r;
         OFS_OUT_TIMING: read_mux = out_timing_r;
         default: read_mux = 8'h00;
      endcase
   endfunction : read_mux

   wire [7:0] rd_instr = read_mux(instr_addr);
   wire [7:0] rd_next = read_mux(next_addr);

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         sclk_d_r <= 1'b0;
         csb_seen_r <= 1'b0;
         state_r <= ST_INSTR;
         bit_cnt_r <= 5'h00;
         in_shift_r <= 16'h0000;
         addr_r <= 13'h0000;
         read_r <= 1'b0;
      end else begin
         sclk_d_r <= sclk_s;
         csb_seen_r <= csb_seen_r | csb_n_s;
         state_r <= state_nxt;
         if (!frame_on) begin
            bit_cnt_r <= 5'h00;
            read_r <= 1'b0;
         end else if (sclk_rise) begin
            in_shift_r <= in_next;
            bit_cnt_r <= (instr_done | byte_done) ? 5'h00 : bit_cnt_r + 5'h01;
            if (instr_done) begin
               addr_r <= instr_addr;
               read_r <= instr_read;
            end else if (byte_done) begin
               addr_r <= next_addr;
            end
         end
      end
   end

   // data driven on falling sclk, msb first; released when the frame closes
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         out_shift_r <= 8'h00;
         spi_sdio_o <= 1'b0;
         spi_sdio_oe_o <= 1'b0;
      end else if (!frame_on) begin
         spi_sdio_oe_o <= 1'b0;
      end else if (instr_done) begin
         out_shift_r <= rd_instr;
      end else if (byte_done & read_r) begin
         out_shift_r <= rd_next;
      end else if (sclk_fall & read_r & (state_r == ST_DATA)) begin
         spi_sdio_o <= out_shift_r[7];
         spi_sdio_oe_o <= 1'b1;
         out_shift_r <= {out_shift_r[6:0], 1'b0};
      end
   end

   // soft reset reloads reset values only into the bytes that do not survive it
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         temp_ctrl_r <= RST_TEMP_CTRL;
         diff_skew_r <= RST_DIFF_SKEW;
         edge_slip_r <= RST_EDGE_SLIP;
      end else if (soft_reset_i) begin
         temp_ctrl_r <= RST_TEMP_CTRL;
         diff_skew_r <= RST_DIFF_SKEW;
         edge_slip_r <= RST_EDGE_SLIP;
      end else if (wr_stb) begin
         if (addr_r == OFS_TEMP_CTRL) temp_ctrl_r <= wr_data;
         if (addr_r == OFS_DIFF_SKEW) diff_skew_r <= wr_data;
         if (addr_r == OFS_EDGE_SLIP) edge_slip_r <= wr_data;
      end
   end

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         clk_div_r <= RST_CLK_DIV;
         out_drv_fmt_r <= RST_OUT_DRV_FMT;
         out_timing_r <= RST_OUT_TIMING;
      end else if (wr_stb) begin
         if (addr_r == OFS_CLK_DIV) clk_div_r <= wr_data;
         if (addr_r == OFS_OUT_DRV_FMT) out_drv_fmt_r <= wr_data;
         if (addr_r == OFS_OUT_TIMING) out_timing_r <= wr_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // field decode; reserved codes raise only the reserved flag
   wire [2:0] div_code = clk_div_r[DIV_LSB +: 3];
   wire [2:0] mode_code = out_drv_fmt_r[MODE_LSB +: 3];
   wire [2:0] fmt_code = out_drv_fmt_r[FMT_LSB +: 3];
   wire div_known = (div_code == DIV_PIN) | (div_code == DIV_BY1) |
                    (div_code == DIV_BY2) | (div_code == DIV_BY4);
   wire [1:0] ratio_dec = (div_code == DIV_BY4) ? RATIO_4 :
                          (div_code == DIV_BY2) ? RATIO_2 : RATIO_1;
   wire mode_known = (mode_code == MODE_DIFF_3MA) | (mode_code == MODE_DIFF_2MA) |
                     (mode_code == MODE_CMOS);
   wire fmt_known = (fmt_code == FMT_TWOS) | (fmt_code == FMT_GRAY) |
                    (fmt_code == FMT_OFFSET);

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         temp_ctrl_o <= RST_TEMP_CTRL;
         temp_enable_o <= 1'b0;
         counter_power_down_o <= 1'b0;
         temp_reset_o <= 1'b0;
         temp_divider_o <= 3'h0;
         temp_select_o <= 1'b0;
         diff_skew_o <= RST_DIFF_SKEW;
         edge_slip_o <= 1'b0;
         div_pin_ctrl_o <= 1'b1;
         div_ratio_o <= RATIO_1;
         div_reserved_o <= 1'b0;
         drive_3ma_o <= 1'b1;
         drive_2ma_o <= 1'b0;
         drive_cmos_o <= 1'b0;
         mode_reserved_o <= 1'b0;
         fmt_twos_o <= 1'b1;
         fmt_gray_o <= 1'b0;
         fmt_offset_o <= 1'b0;
         fmt_reserved_o <= 1'b0;
         dll_slow_o <= 1'b0;
         ddr_enable_o <= 1'b0;
      end else begin
         temp_ctrl_o <= temp_ctrl_r;
         temp_enable_o <= temp_ctrl_r[TC_ENABLE_BIT];
         counter_power_down_o <= temp_ctrl_r[TC_PD_BIT];
         temp_reset_o <= temp_ctrl_r[TC_RESET_BIT];
         temp_divider_o <= temp_ctrl_r[TC_DIV_LSB +: 3];
         temp_select_o <= temp_ctrl_r[TC_SELECT_BIT];
         diff_skew_o <= diff_skew_r;
         edge_slip_o <= edge_slip_r[SLIP_BIT];
         div_pin_ctrl_o <= (div_code == DIV_PIN);
         div_ratio_o <= ratio_dec;
         div_reserved_o <= ~div_known;
         drive_3ma_o <= (mode_code == MODE_DIFF_3MA);
         drive_2ma_o <= (mode_code == MODE_DIFF_2MA);
         drive_cmos_o <= (mode_code == MODE_CMOS);
         mode_reserved_o <= ~mode_known;
         fmt_twos_o <= (fmt_code == FMT_TWOS);
         fmt_gray_o <= (fmt_code == FMT_GRAY);
         fmt_offset_o <= (fmt_code == FMT_OFFSET);
         fmt_reserved_o <= ~fmt_known;
         dll_slow_o <= out_timing_r[DLL_BIT];
         ddr_enable_o <= out_timing_r[DDR_BIT];
      end
   end
endmodule : adccr_regs
`default_nettype wire

/* File: tb/adccr_regs_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module adccr_regs_sva (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic soft_reset_i,
   input wire logic spi_csb_n_i,
   input wire logic spi_sdio_oe_o,
   input wire logic [7:0] temp_ctrl_o,
   input wire logic [7:0] diff_skew_o,
   input wire logic edge_slip_o,
   input wire logic div_pin_ctrl_o,
   input wire logic [1:0] div_ratio_o,
   input wire logic div_reserved_o,
   input wire logic drive_3ma_o,
   input wire logic drive_2ma_o,
   input wire logic drive_cmos_o,
   input wire logic mode_reserved_o,
   input wire logic fmt_twos_o,
   input wire logic fmt_gray_o,
   input wire logic fmt_offset_o,
   input wire logic fmt_reserved_o,
   input wire logic dll_slow_o,
   input wire logic ddr_enable_o
);
   import adccr_pkg::*;
   wire [3:0] mode_w = {drive_3ma_o, drive_2ma_o, drive_cmos_o, mode_reserved_o};
   wire [3:0] fmt_w = {fmt_twos_o, fmt_gray_o, fmt_offset_o, fmt_reserved_o};
   default clocking @(posedge clock_i); endclocking
   default disable iff (reset_i);
   ////////////////////////////////////////
   chk_div_pin: assert property (div_pin_ctrl_o |-> div_ratio_o == RATIO_1)
      else $error("pin control with a ratio");
   chk_div_res: assert property (div_reserved_o |-> !div_pin_ctrl_o && div_ratio_o == RATIO_1)
      else $error("reserved divide code acted upon");
   chk_mode_hot: assert property ($onehot(mode_w))
      else $error("output mode decode not one-hot");
   chk_fmt_hot: assert property ($onehot(fmt_w))
      else $error("format decode not one-hot");
   chk_reset_vals: assert property ($fell(reset_i) |-> mode_w == 4'h8 && fmt_w == 4'h8
      && div_pin_ctrl_o && !dll_slow_o && !ddr_enable_o)
      else $error("wrong values after reset");
   chk_soft_keep: assert property (soft_reset_i && spi_csb_n_i && $past(spi_csb_n_i, 8)
      |=> $stable({mode_w, fmt_w, dll_slow_o, ddr_enable_o, div_ratio_o, div_pin_ctrl_o}))
      else $error("soft reset disturbed kept bytes");
   chk_soft_restore: assert property (soft_reset_i |-> ##[1:2] diff_skew_o == RST_DIFF_SKEW
      && temp_ctrl_o == RST_TEMP_CTRL && !edge_slip_o)
      else $error("soft reset did not restore bytes");
   chk_oe_idle: assert property (spi_csb_n_i [*8] |-> !spi_sdio_oe_o)
      else $error("sdio driven while deselected");
   cover property (soft_reset_i);
   cover property ($rose(div_reserved_o));
   cover property ($rose(spi_sdio_oe_o));
endmodule : adccr_regs_sva
bind adccr_regs adccr_regs_sva sva_u (.*);
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
   import adccr_pkg::*;
   logic clock_i, reset_i, soft_reset_i, spi_sclk_i, spi_csb_n_i, spi_sdio_i;
   logic spi_sdio_o, spi_sdio_oe_o, temp_enable_o, counter_power_down_o, temp_reset_o;
   logic temp_select_o, edge_slip_o, div_pin_ctrl_o, div_reserved_o, drive_3ma_o;
   logic drive_2ma_o, drive_cmos_o, mode_reserved_o, fmt_twos_o, fmt_gray_o;
   logic fmt_offset_o, fmt_reserved_o, dll_slow_o, ddr_enable_o;
   logic [7:0] temp_ctrl_o, diff_skew_o, rd;
   logic [2:0] temp_divider_o;
   logic [1:0] div_ratio_o;
   int error_cnt = 0;
   int checked = 0;
   adccr_regs dut_u (.*);
   initial begin
      clock_i = 1'b0;
      forever #25 clock_i = ~clock_i;
   end
   ////////////////////////////////////////
   task automatic tick(input int n);
      repeat (n) @(posedge clock_i);
      #5;
   endtask : tick
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   // slow sclk phases leave room for the pin synchronisers
   task automatic bit_cyc(input logic b);
      spi_sdio_i = b;
      tick(5);
      // a released line reads inverted so a stale bit cannot pass
      rd = {rd[6:0], spi_sdio_oe_o ? spi_sdio_o : ~spi_sdio_o};
      spi_sclk_i = 1'b1;
      tick(5);
      spi_sclk_i = 1'b0;
   endtask : bit_cyc
   task automatic xfer(input logic r, input logic [12:0] a, input logic [7:0] d);
      logic [23:0] w;
      w = {r, 2'b00, a, d};
      spi_csb_n_i = 1'b0;
      for (int i = 23; i >= 0; i--) bit_cyc(w[i]);
      tick(5);
      spi_csb_n_i = 1'b1;
      tick(10);
   endtask : xfer
   task automatic rchk(input logic [12:0] a, input logic [7:0] exp);
      xfer(1'b1, a, 8'h00);
      cmp(rd, exp);
   endtask : rchk
   ////////////////////////////////////////
   task automatic t_reset();
      cmp({4'h0, drive_3ma_o, fmt_twos_o, div_pin_ctrl_o, dll_slow_o}, 8'h0e);
      rchk(OFS_TEMP_CTRL, RST_TEMP_CTRL);
      rchk(OFS_DIFF_SKEW, RST_DIFF_SKEW);
      rchk(OFS_EDGE_SLIP, RST_EDGE_SLIP);
      rchk(OFS_CLK_DIV, RST_CLK_DIV);
      rchk(OFS_OUT_DRV_FMT, RST_OUT_DRV_FMT);
      rchk(OFS_OUT_TIMING, RST_OUT_TIMING);
   endtask : t_reset
   task automatic t_div();
      logic [1:0] rt;
      for (int k = 0; k < 8; k++) begin
         rt = (k == 2) ? RATIO_2 : (k == 4) ? RATIO_4 : RATIO_1;
         xfer(1'b0, OFS_CLK_DIV, 8'(k));
         cmp({4'h0, div_pin_ctrl_o, div_reserved_o, div_ratio_o},
            {4'h0, k == 0, !(k inside {0, 1, 2, 4}), rt});
         rchk(OFS_CLK_DIV, 8'(k));
      end
   endtask : t_div
   task automatic t_out();
      for (int k = 0; k < 8; k++) begin
         xfer(1'b0, OFS_OUT_DRV_FMT, {3'(k), 2'b00, 3'(k)});
         cmp({4'h0, drive_3ma_o, drive_2ma_o, drive_cmos_o, mode_reserved_o},
            {4'h0, k == 0, k == 1, k == 4, !(k inside {0, 1, 4})});
         cmp({4'h0, fmt_twos_o, fmt_gray_o, fmt_offset_o, fmt_reserved_o},
            {4'h0, k == 0, k == 2, k == 4, !(k inside {0, 2, 4})});
      end
   endtask : t_out
   task automatic t_misc();
      xfer(1'b0, OFS_OUT_TIMING, 8'h40);
      cmp({6'h0, dll_slow_o, ddr_enable_o}, 8'h02);
      xfer(1'b0, OFS_OUT_TIMING, 8'h10);
      cmp({6'h0, dll_slow_o, ddr_enable_o}, 8'h01);
      xfer(1'b0, OFS_TEMP_CTRL, 8'ha5);
      cmp(temp_ctrl_o, 8'ha5);
      cmp({1'b0, temp_enable_o, counter_power_down_o, temp_reset_o, temp_divider_o,
         temp_select_o}, 8'h55);
      xfer(1'b0, OFS_EDGE_SLIP, 8'h01);
      cmp({7'h0, edge_slip_o}, 8'h01);
      xfer(1'b0, 13'h0050, 8'h5a);
      rchk(13'h0050, 8'h00);
   endtask : t_misc
   task automatic t_soft();
      xfer(1'b0, OFS_CLK_DIV, 8'h02);
      xfer(1'b0, OFS_OUT_DRV_FMT, 8'h22);
      xfer(1'b0, OFS_OUT_TIMING, 8'h50);
      xfer(1'b0, OFS_DIFF_SKEW, 8'h12);
      cmp(diff_skew_o, 8'h12);
      soft_reset_i = 1'b1;
      tick(2);
      soft_reset_i = 1'b0;
      tick(3);
      cmp(diff_skew_o, RST_DIFF_SKEW);
      cmp(temp_ctrl_o, RST_TEMP_CTRL);
      cmp({7'h0, edge_slip_o}, 8'h00);
      cmp({4'h0, div_ratio_o, drive_2ma_o, fmt_gray_o}, 8'h07);
      cmp({6'h0, dll_slow_o, ddr_enable_o}, 8'h03);
      rchk(OFS_CLK_DIV, 8'h02);
      rchk(OFS_OUT_DRV_FMT, 8'h22);
      rchk(OFS_OUT_TIMING, 8'h50);
   endtask : t_soft
   // power-up reset in mid-run must clear the bytes that soft reset keeps
   task automatic t_hard();
      reset_i = 1'b1;
      tick(2);
      reset_i = 1'b0;
      tick(4);
      cmp({4'h0, drive_3ma_o, fmt_twos_o, div_pin_ctrl_o, dll_slow_o}, 8'h0e);
      rchk(OFS_CLK_DIV, RST_CLK_DIV);
      rchk(OFS_OUT_DRV_FMT, RST_OUT_DRV_FMT);
      rchk(OFS_OUT_TIMING, RST_OUT_TIMING);
   endtask : t_hard
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : tally_and_finish
   ////////////////////////////////////////
   initial begin
      reset_i = 1'b1;
      soft_reset_i = 1'b0;
      spi_sclk_i = 1'b0;
      spi_csb_n_i = 1'b1;
      spi_sdio_i = 1'b0;
      rd = 8'h00;
      tick(12);
      reset_i = 1'b0;
      tick(4);
      t_reset();
      t_div();
      t_out();
      t_misc();
      t_soft();
      t_hard();
      tally_and_finish();
   end
   initial begin
      tick(30000);
      error_cnt++;
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire
